// ==== seap_pkg.sv ====
// Constants shared by the serial EEPROM command engine and its memories.
// Assumes a 100 MHz system clock that oversamples the serial link pins.
//
// Contract
// - Block-protect bits 00 none, 01 upper quarter, 10 upper half, 11 whole array.
// - Hardware protection holds only while protect pin low and pin-enable bit set.
// - Under hardware protection status writes are refused; unprotected array writes still work.
// - Pin-enable bit cannot be cleared while hardware protection holds.
// - Latch clear blocks every write; latch set allows unprotected array and status.
// - Read: opcode, 16-bit address, then addressed byte shifted out MSB first.
// - Sequential read increments address and wraps from top address to zero.
// - Only locations outside the block-protected range are ever programmed.
// - During programming every instruction except status read is ignored.
// - Write: opcode, address, data bytes; programming starts after select rises.
// - Status bit 0 reads 1 while programming runs, 0 once it ends.
// - Write address increments only its five low bits, wrapping in 32 bytes.
// - Completion of a programming cycle clears the write-enable latch.
// - Write with latch clear is ignored until select rises and falls again.
// - First byte is the opcode with bit 3 ignored; six opcodes decoded.
// - Status byte: pin-enable 7, protect 3..2, latch 1, busy 0; all ones busy.
// - Every byte travels MSB first and each frame opens with select falling.
// - Write-enable latch is clear after power-up.
package seap_pkg;

  // Part size: 1 selects the 2048-byte part, 0 the 1024-byte part.
  localparam logic        IS_16K       = 1'b1;
  localparam int          ADDR_BITS    = 11;
  localparam logic [10:0] ADDR_MASK    = IS_16K ? 11'h7ff : 11'h3ff;
  localparam int          PAGE_BITS    = 5;
  localparam int          PAGE_BYTES   = 32;
  localparam int          BYTE_BITS    = 8;

  // Opcodes with bit 3 forced to zero before comparison.
  localparam logic [7:0]  OPC_BIT3_MASK        = 8'hf7;
  localparam logic [7:0]  OPC_SET_WRITE_LATCH  = 8'h06;
  localparam logic [7:0]  OPC_CLR_WRITE_LATCH  = 8'h04;
  localparam logic [7:0]  OPC_STATUS_READ      = 8'h05;
  localparam logic [7:0]  OPC_STATUS_WRITE     = 8'h01;
  localparam logic [7:0]  OPC_READ             = 8'h03;
  localparam logic [7:0]  OPC_WRITE            = 8'h02;

  // Status byte layout.
  localparam int          SR_PIN_ENABLE_BIT = 7;
  localparam int          SR_BP_HI_BIT      = 3;
  localparam int          SR_BP_LO_BIT      = 2;
  localparam int          SR_LATCH_BIT      = 1;
  localparam int          SR_BUSY_BIT       = 0;
  localparam logic [7:0]  SR_BUSY_VALUE     = 8'hff;

  // Power-up values of the latch and the nonvolatile status bits.
  localparam logic        RST_WRITE_LATCH   = 1'b0;
  localparam logic        RST_PIN_ENABLE    = 1'b0;
  localparam logic [1:0]  RST_BLOCK_PROTECT = 2'h0;

  // Self-timed write cycle.
  localparam int          CLK_MHZ    = 100;
  localparam int          TWC_US     = 5000;
  localparam int          TWC_CYCLES = TWC_US * CLK_MHZ;

  // Read data buffer in front of the output shifter.
  localparam int          RBUF_DEPTH = 2;

  // Positions of the pins in the synchroniser vector.
  localparam int          PIN_CS  = 3;
  localparam int          PIN_SCK = 2;
  localparam int          PIN_SI  = 1;
  localparam int          PIN_WP  = 0;

  // Frame engine states.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_OPCODE  = 4'b0001,
    ST_ADDR_HI = 4'b0010,
    ST_ADDR_LO = 4'b0011,
    ST_READ    = 4'b0100,
    ST_SREAD   = 4'b0101,
    ST_WRITE   = 4'b0110,
    ST_SWRITE  = 4'b0111,
    ST_IGNORE  = 4'b1000
  } seap_state_e;

endpackage

// ==== seap_mem.sv ====
// Simple dual-port byte memory with a registered read port.
// Assumes one clock; contents are not reset, only the read register is.
`timescale 1ns/10ps
module seap_mem #(
  parameter int DW = 8,
  parameter int AW = 11
) (
  input  wire logic          clk,    // System clock.
  input  wire logic          rst,    // Asynchronous reset, active high.
  input  wire logic          we,     // Write strobe.
  input  wire logic [AW-1:0] waddr,  // Write address.
  input  wire logic [DW-1:0] wdata,  // Write data.
  input  wire logic          re,     // Read strobe.
  input  wire logic [AW-1:0] raddr,  // Read address.
  output logic      [DW-1:0] rdata   // Read data, valid the cycle after re.
);

  logic [DW-1:0] store [0:(1<<AW)-1];

  // Storage write port.
  always_ff @(posedge clk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  // Registered read port.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= store[raddr];
    end
  end

endmodule

// ==== seap_top.sv ====
// Serial EEPROM command engine: link receiver, decoder, protection and page programming.
// Assumes the link pins come from outside this clock domain and SCK is far slower.
`timescale 1ns/10ps
module seap_top #(
  parameter int PROG_CYCLES = seap_pkg::TWC_CYCLES
) (
  input  wire logic sys_clk,            // System clock, 100 MHz.
  input  wire logic rst,                // Asynchronous reset, active high.
  input  wire logic spi_cs_n,           // Chip select from the master, active low.
  input  wire logic spi_sck,            // Serial clock from the master.
  input  wire logic spi_si,             // Serial data in.
  input  wire logic wp_n,               // Write-protect pin, active low.
  output logic      spi_so,             // Serial data out.
  output logic      spi_so_oe,          // Output enable of serial data out.
  output logic      write_busy,         // Programming cycle in progress.
  output logic      write_latch,        // Write-enable latch.
  output logic      protect_pin_enable, // Pin-enable status bit.
  output logic      block_protect_hi,   // Upper block-protect bit.
  output logic      block_protect_lo    // Lower block-protect bit.
);
  import seap_pkg::*;

  logic [3:0]                 sync1;
  logic [3:0]                 sync2;
  logic                       sck_d;
  logic                       cs_d;
  logic                       cs_n_s;
  logic                       sck_s;
  logic                       si_s;
  logic                       wp_n_s;
  logic                       sck_rise;
  logic                       sck_fall;
  logic                       cs_fall;
  logic                       cs_rise;
  logic [2:0]                 bit_cnt;
  logic [6:0]                 shift_in;
  logic                       byte_done;
  logic [7:0]                 rx_byte;
  logic [7:0]                 opc;
  seap_state_e                state;
  logic                       is_read;
  logic [ADDR_BITS-1:0]       addr;
  logic                       hw_prot;
  logic                       set_latch;
  logic                       clr_latch;
  logic [7:0]                 sr_new;
  logic                       sr_have;
  logic                       sr_kind;
  logic                       prog_start;
  logic                       prog_done;
  logic [19:0]                timer;
  logic [PAGE_BYTES-1:0]      page_mask;
  logic [ADDR_BITS-PAGE_BITS-1:0] page_base;
  logic [5:0]                 copy_idx;
  logic                       copy_rd;
  logic                       copy_wr;
  logic [PAGE_BITS-1:0]       copy_idx_d;
  logic [7:0]                 pbuf_rdata;
  logic [ADDR_BITS-1:0]       arr_waddr;
  logic                       arr_we;
  logic                       pbuf_we;
  logic                       rd_issue;
  logic                       rd_inflight;
  logic [7:0]                 arr_rdata;
  logic [7:0]                 rbuf [0:RBUF_DEPTH-1];
  logic                       rbuf_wp;
  logic                       rbuf_rp;
  logic [1:0]                 rbuf_cnt;
  logic                       rbuf_ready;
  logic                       rbuf_push;
  logic                       rbuf_pop;
  logic                       load_byte;
  logic [7:0]                 load_value;
  logic [7:0]                 status_byte;
  logic [6:0]                 tx;

  // True when the address lies in the range chosen by the block-protect level.
  function automatic logic blocked(input logic [ADDR_BITS-1:0] a, input logic [1:0] bp);
    logic [1:0] top2;
    top2 = IS_16K ? a[10:9] : a[9:8];
    case (bp)
      2'h0:    blocked = 1'b0;
      2'h1:    blocked = (top2 == 2'h3);
      2'h2:    blocked = top2[1];
      default: blocked = 1'b1;
    endcase
  endfunction

  // Two-flop synchronisers for every pin, plus a third stage for edge detection.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1 <= 4'h9;
      sync2 <= 4'h9;
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sync1 <= {spi_cs_n, spi_sck, spi_si, wp_n};
      sync2 <= sync1;
      sck_d <= sync2[PIN_SCK];
      cs_d  <= sync2[PIN_CS];
    end
  end

  // Synchronised pins and their edges; clock edges count only while selected.
  assign cs_n_s   = sync2[PIN_CS];
  assign sck_s    = sync2[PIN_SCK];
  assign si_s     = sync2[PIN_SI];
  assign wp_n_s   = sync2[PIN_WP];
  assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d & ~cs_n_s;
  assign cs_fall  = ~cs_n_s & cs_d;
  assign cs_rise  = cs_n_s & ~cs_d;

  // Input shifter, MSB first, counting bits within the current byte.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_cnt  <= 3'h0;
      shift_in <= 7'h00;
    end else if (cs_n_s) begin
      bit_cnt  <= 3'h0;
    end else if (sck_rise) begin
      shift_in <= {shift_in[5:0], si_s};
      bit_cnt  <= bit_cnt + 3'h1;
    end
  end

  // A whole byte is in on the rising edge that carries its eighth bit.
  assign byte_done = sck_rise & (bit_cnt == 3'h7);
  assign rx_byte   = {shift_in, si_s};
  assign opc       = rx_byte & OPC_BIT3_MASK;
  assign hw_prot   = protect_pin_enable & ~wp_n_s;

  // Latch instructions act at the end of their opcode byte, never while busy.
  assign set_latch = byte_done & (state == ST_OPCODE) & (opc == OPC_SET_WRITE_LATCH)
                     & ~write_busy;
  assign clr_latch = byte_done & (state == ST_OPCODE) & (opc == OPC_CLR_WRITE_LATCH)
                     & ~write_busy;

  // Frame state machine: opcode decode, address capture and data phases.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state   <= ST_IDLE;
      is_read <= 1'b0;
    end else if (cs_n_s) begin
      state   <= ST_IDLE;
    end else if (cs_fall) begin
      state   <= ST_OPCODE;
    end else if (byte_done) begin
      case (state)
        ST_OPCODE: begin
          // Anything other than status read is dropped while programming.
          if (write_busy && opc != OPC_STATUS_READ) begin
            state <= ST_IGNORE;
          end else begin
            case (opc)
              OPC_STATUS_READ:  state <= ST_SREAD;
              OPC_STATUS_WRITE: state <= write_latch ? ST_SWRITE : ST_IGNORE;
              OPC_READ: begin
                state   <= ST_ADDR_HI;
                is_read <= 1'b1;
              end
              OPC_WRITE: begin
                state   <= write_latch ? ST_ADDR_HI : ST_IGNORE;
                is_read <= 1'b0;
              end
              default:          state <= ST_IGNORE;
            endcase
          end
        end
        ST_ADDR_HI: state <= ST_ADDR_LO;
        ST_ADDR_LO: state <= is_read ? ST_READ : ST_WRITE;
        default:    state <= state;
      endcase
    end
  end

  // Byte address: captured from the frame, then stepped by reads and writes.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr <= '0;
    end else if (byte_done && state == ST_ADDR_HI) begin
      addr[10:8] <= rx_byte[2:0] & ADDR_MASK[10:8];
    end else if (byte_done && state == ST_ADDR_LO) begin
      addr[7:0] <= rx_byte;
    end else if (rd_issue) begin
      addr <= (addr + 11'h001) & ADDR_MASK;
    end else if (byte_done && state == ST_WRITE) begin
      addr[PAGE_BITS-1:0] <= addr[PAGE_BITS-1:0] + 5'h01;
    end
  end

  // Page buffer fill: each received data byte lands at the low address bits.
  assign pbuf_we = byte_done & (state == ST_WRITE);

  // Mask of page bytes written in this frame, and the page they belong to.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      page_mask <= '0;
      page_base <= '0;
    end else if (prog_done) begin
      page_mask <= '0;
    end else if (byte_done && state == ST_ADDR_LO && !is_read) begin
      page_mask <= '0;
      page_base <= {addr[10:8], rx_byte[7:5]};
    end else if (pbuf_we) begin
      page_mask[addr[PAGE_BITS-1:0]] <= 1'b1;
    end
  end

  // New status value from a status-write frame; only the first data byte counts.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sr_new  <= 8'h00;
      sr_have <= 1'b0;
    end else if (cs_fall) begin
      sr_have <= 1'b0;
    end else if (byte_done && state == ST_SWRITE && !sr_have) begin
      sr_new  <= rx_byte;
      sr_have <= 1'b1;
    end
  end

  // Programming starts only as select rises on a byte boundary with work to do.
  assign prog_start = cs_rise & (bit_cnt == 3'h0) & ~write_busy &
                      (((state == ST_WRITE) & (page_mask != '0)) |
                       ((state == ST_SWRITE) & sr_have & ~hw_prot));
  assign prog_done  = write_busy & (timer == PROG_CYCLES[19:0] - 20'h1);

  // Self-timed cycle counter and busy flag.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      write_busy <= 1'b0;
      timer      <= 20'h0;
      sr_kind    <= 1'b0;
    end else if (prog_start) begin
      write_busy <= 1'b1;
      timer      <= 20'h0;
      sr_kind    <= (state == ST_SWRITE);
    end else if (prog_done) begin
      write_busy <= 1'b0;
    end else if (write_busy) begin
      timer      <= timer + 20'h1;
    end
  end

  // Write-enable latch; a finished cycle clears it even against a set.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      write_latch <= RST_WRITE_LATCH;
    end else if (prog_done) begin
      write_latch <= 1'b0;
    end else if (set_latch) begin
      write_latch <= 1'b1;
    end else if (clr_latch) begin
      write_latch <= 1'b0;
    end
  end

  // Nonvolatile status bits take their new value as the cycle completes.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      protect_pin_enable <= RST_PIN_ENABLE;
      block_protect_hi   <= RST_BLOCK_PROTECT[1];
      block_protect_lo   <= RST_BLOCK_PROTECT[0];
    end else if (prog_done && sr_kind) begin
      protect_pin_enable <= sr_new[SR_PIN_ENABLE_BIT];
      block_protect_hi   <= sr_new[SR_BP_HI_BIT];
      block_protect_lo   <= sr_new[SR_BP_LO_BIT];
    end
  end

  // Copy walk: read each page byte, then program it one cycle later.
  assign copy_rd   = write_busy & ~sr_kind & ~copy_idx[5];
  assign arr_waddr = {page_base, copy_idx_d};
  assign arr_we    = copy_wr & page_mask[copy_idx_d] &
                     ~blocked(arr_waddr, {block_protect_hi, block_protect_lo});

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      copy_idx   <= 6'h00;
      copy_wr    <= 1'b0;
      copy_idx_d <= '0;
    end else begin
      copy_wr    <= copy_rd;
      copy_idx_d <= copy_idx[PAGE_BITS-1:0];
      if (prog_start) begin
        copy_idx <= 6'h00;
      end else if (copy_rd) begin
        copy_idx <= copy_idx + 6'h01;
      end
    end
  end

  // Page buffer holding the bytes of one write frame.
  seap_mem #(.DW(8), .AW(PAGE_BITS)) u_page (
    .clk   (sys_clk),
    .rst   (rst),
    .we    (pbuf_we),
    .waddr (addr[PAGE_BITS-1:0]),
    .wdata (rx_byte),
    .re    (copy_rd),
    .raddr (copy_idx[PAGE_BITS-1:0]),
    .rdata (pbuf_rdata)
  );

  // Main array.
  seap_mem #(.DW(8), .AW(ADDR_BITS)) u_array (
    .clk   (sys_clk),
    .rst   (rst),
    .we    (arr_we),
    .waddr (arr_waddr),
    .wdata (pbuf_rdata),
    .re    (rd_issue),
    .raddr (addr),
    .rdata (arr_rdata)
  );

  // Read prefetch: fetch ahead while the two-entry buffer has a free slot.
  assign rbuf_ready = (rbuf_cnt != 2'(RBUF_DEPTH));
  assign rd_issue   = (state == ST_READ) & ~cs_n_s & ~rd_inflight &
                      (rbuf_cnt == 2'h0 || (rbuf_cnt == 2'h1 && !rbuf_pop));
  assign rbuf_push  = rd_inflight & rbuf_ready;
  assign rbuf_pop   = sck_fall & (bit_cnt == 3'h0) & (state == ST_READ) & (rbuf_cnt != 2'h0);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_inflight <= 1'b0;
    end else if (state != ST_READ) begin
      rd_inflight <= 1'b0;
    end else begin
      rd_inflight <= rd_issue;
    end
  end

  // Two-entry read buffer between the array and the output shifter.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rbuf_wp  <= 1'b0;
      rbuf_rp  <= 1'b0;
      rbuf_cnt <= 2'h0;
      rbuf[0]  <= 8'h00;
      rbuf[1]  <= 8'h00;
    end else if (state != ST_READ) begin
      rbuf_wp  <= 1'b0;
      rbuf_rp  <= 1'b0;
      rbuf_cnt <= 2'h0;
    end else begin
      if (rbuf_push) begin
        rbuf[rbuf_wp] <= arr_rdata;
        rbuf_wp       <= ~rbuf_wp;
      end
      if (rbuf_pop) begin
        rbuf_rp <= ~rbuf_rp;
      end
      rbuf_cnt <= rbuf_cnt + {1'b0, rbuf_push} - {1'b0, rbuf_pop};
    end
  end

  // Status byte as seen by a status read; all ones while programming.
  assign status_byte = write_busy ? SR_BUSY_VALUE :
                       {protect_pin_enable, 3'h0, block_protect_hi, block_protect_lo,
                        write_latch, 1'b0};
  assign load_byte   = sck_fall & (bit_cnt == 3'h0) &
                       (((state == ST_READ) & (rbuf_cnt != 2'h0)) | (state == ST_SREAD));
  assign load_value  = (state == ST_SREAD) ? status_byte : rbuf[rbuf_rp];

  // Output shifter: changes after falling edges, released when deselected.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      spi_so    <= 1'b0;
      spi_so_oe <= 1'b0;
      tx        <= 7'h00;
    end else if (cs_n_s) begin
      spi_so    <= 1'b0;
      spi_so_oe <= 1'b0;
    end else if (load_byte) begin
      spi_so    <= load_value[7];
      tx        <= load_value[6:0];
      spi_so_oe <= 1'b1;
    end else if (sck_fall && spi_so_oe) begin
      spi_so    <= tx[6];
      tx        <= {tx[5:0], 1'b0};
    end
  end

endmodule

// ==== seap_sva.sv ====
// Port assertions for the serial EEPROM engine, bound into seap_top.
// Assumes one sys_clk domain with rst asynchronous and active high.
`timescale 1ns/10ps
module seap_sva #(
  parameter int PROG_CYCLES = 64
) (
  input wire logic sys_clk,            // System clock.
  input wire logic rst,                // Reset, active high.
  input wire logic spi_cs_n,           // Chip select, active low.
  input wire logic spi_sck,            // Serial clock.
  input wire logic spi_si,             // Serial data in.
  input wire logic wp_n,               // Protect pin, active low.
  input wire logic spi_so,             // Serial data out.
  input wire logic spi_so_oe,          // Output enable.
  input wire logic write_busy,         // Programming running.
  input wire logic write_latch,        // Write-enable latch.
  input wire logic protect_pin_enable, // Pin-enable bit.
  input wire logic block_protect_hi,   // Upper protect bit.
  input wire logic block_protect_lo    // Lower protect bit.
);
  int busy_cnt;
  // Counts busy cycles so the programming time can be held to its figure.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) busy_cnt <= 0;
    else busy_cnt <= write_busy ? busy_cnt + 1 : 0;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence prog_start;
    $rose(write_busy);
  endsequence
  sequence prog_end;
    $fell(write_busy);
  endsequence
  release_idle_a: assert property (spi_cs_n [*4] |-> !spi_so_oe)
    else $error("so driven while deselected");
  so_quiet_a: assert property (!spi_so_oe |-> !spi_so)
    else $error("so not parked while released");
  so_on_fall_a: assert property ($changed(spi_so) && spi_so_oe && $past(spi_so_oe)
    |-> !spi_sck)
    else $error("so changed while the serial clock was high");
  latch_drop_a: assert property (prog_end |-> !write_latch)
    else $error("latch still set after programming");
  start_cs_a: assert property (prog_start |-> $past(spi_cs_n))
    else $error("programming began while selected");
  start_latch_a: assert property (prog_start |-> $past(write_latch))
    else $error("programming began without latch");
  prog_time_a: assert property (prog_end |-> busy_cnt == PROG_CYCLES)
    else $error("busy length wrong");
  bits_at_end_a: assert property ($changed({protect_pin_enable, block_protect_hi,
    block_protect_lo}) |-> !write_busy && ($past(write_busy) || $past(write_busy, 2)))
    else $error("status bits changed outside a cycle end");
  latch_idle_a: assert property ($rose(write_latch) |-> !write_busy && !spi_cs_n)
    else $error("latch set while busy or deselected");
endmodule
bind seap_top seap_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.sys_clk(sys_clk), .rst(rst),
  .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si), .wp_n(wp_n), .spi_so(spi_so),
  .spi_so_oe(spi_so_oe), .write_busy(write_busy), .write_latch(write_latch),
  .protect_pin_enable(protect_pin_enable), .block_protect_hi(block_protect_hi),
  .block_protect_lo(block_protect_lo));

// ==== seap_master.sv ====
// Mode 0 serial master model standing at the far side of the EEPROM link.
// Assumes the bench loads tx and calls frame; paced on sys_clk falling edges.
`timescale 1ns/10ps
module seap_master (
  input  wire logic sys_clk, // Pacing clock.
  input  wire logic so,      // Device serial out.
  input  wire logic so_oe,   // Device drives so.
  output logic      cs_n,    // Chip select, active low.
  output logic      sck,     // Serial clock, low between frames.
  output logic      si       // Serial data to the device.
);
  logic [7:0] tx[40];
  logic [7:0] rx[40];
  // The link idles deselected with the clock standing low.
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // One frame of n bytes, MSB first, 80 ns clock.
  task automatic frame(input int n);
    cs_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        si = tx[b][i];
        repeat (4) @(negedge sys_clk);
        sck = 1'b1;
        rx[b][i] = so_oe ? so : 1'bx;
        repeat (4) @(negedge sys_clk);
        sck = 1'b0;
      end
    end
    @(negedge sys_clk);
    cs_n = 1'b1; // Select rises in the low phase after the last bit.
    si   = ~si;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule

// ==== tb_seap_top.sv ====
// Self-checking bench for seap_top: protection, page write, read wrap, busy polling.
// Assumes seap_master on the link and a shortened programming time.
`timescale 1ns/10ps
module tb_seap_top;
  import seap_pkg::*;
  localparam int PC = 400;
  typedef struct packed {logic wp; logic [7:0] sr; logic [3:0] want;} seap_row_s;
  logic sys_clk = 1'b0;
  logic rst     = 1'b1;
  logic wp_n    = 1'b1;
  logic cs_n, sck, si, so, so_oe, busy, wel, pe, bph, bpl;
  int failures   = 0;
  int n_compared = 0;
  // Rows: pin level, status byte written, then {pin enable, protect bits, latch}.
  seap_row_s rows[6] = '{'{1'b1, 8'h0c, 4'h6}, '{1'b1, 8'h84, 4'ha}, '{1'b0, 8'h00, 4'hb},
    '{1'b1, 8'h08, 4'h4}, '{1'b0, 8'h04, 4'h2}, '{1'b1, 8'h00, 4'h0}};
  // The 100 MHz system clock.
  always #5 sys_clk = ~sys_clk;
  seap_top #(.PROG_CYCLES(PC)) dut (.sys_clk(sys_clk), .rst(rst), .spi_cs_n(cs_n),
    .spi_sck(sck), .spi_si(si), .wp_n(wp_n), .spi_so(so), .spi_so_oe(so_oe),
    .write_busy(busy), .write_latch(wel), .protect_pin_enable(pe),
    .block_protect_hi(bph), .block_protect_lo(bpl));
  seap_master m (.sys_clk(sys_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));
  // Compares one value and reports a difference at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Short frame helpers: command, busy wait, page write and read.
  task automatic cmd1(input logic [7:0] op);
    m.tx[0] = op;
    m.frame(1);
  endtask
  task automatic idle();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge sys_clk);
    check({7'h0, busy}, 8'h00);
  endtask
  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] v, input bit en);
    if (en) cmd1(8'h06);
    m.tx[0] = 8'h02;
    m.tx[1] = a[15:8];
    m.tx[2] = a[7:0];
    for (int k = 0; k < n; k++) m.tx[3+k] = v + 8'(k);
    m.frame(3 + n);
    idle();
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    m.tx[0] = 8'h03;
    m.tx[1] = a[15:8];
    m.tx[2] = a[7:0];
    m.frame(3 + n);
  endtask
  // Watchdog: the tests need about 110 us, so 300 us means a hang.
  initial begin
    #300_000;
    failures++;
    end_sim();
  end
  // Main sequence: reset, table of status writes, then the awkward cases.
  initial begin
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    check({2'h0, pe, bph, bpl, wel, busy, so_oe}, 8'h00);
    repeat (4) @(negedge sys_clk);
    foreach (rows[r]) begin
      wp_n = rows[r].wp;
      cmd1(8'h06);
      m.tx[0] = 8'h01;
      m.tx[1] = rows[r].sr;
      m.frame(2);
      idle();
      check({4'h0, pe, bph, bpl, wel}, {4'h0, rows[r].want});
    end
    wp_n = 1'b1;
    wr(16'h0000, 2, 8'ha0, 1'b1);
    wr(16'h07e0, 33, 8'h40, 1'b1);
    rd(16'hf7fe, 4);
    check(m.rx[3], 8'h5e);
    check(m.rx[4], 8'h5f);
    check(m.rx[5], 8'ha0);
    check(m.rx[6], 8'ha1);
    cmd1(8'h0e);
    check({7'h0, wel}, 8'h01);
    cmd1(8'h04);
    check({7'h0, wel}, 8'h00);
    cmd1(8'h16);
    check({7'h0, wel}, 8'h00);
    cmd1(8'h06);
    m.tx[0] = 8'h01;
    m.tx[1] = 8'h84;
    m.frame(2);
    cmd1(8'h04);
    check({6'h0, wel, busy}, 8'h03);
    m.tx[0] = 8'h05;
    m.frame(2);
    check(m.rx[1], 8'hff);
    idle();
    m.frame(2);
    check(m.rx[1], 8'h84);
    wp_n = 1'b0;
    wr(16'h07e0, 1, 8'h11, 1'b1);
    wr(16'h05e0, 1, 8'h22, 1'b1);
    rd(16'h07e0, 1);
    check(m.rx[3], 8'h60);
    wr(16'h05e0, 1, 8'h33, 1'b0);
    rd(16'h05e0, 1);
    check(m.rx[3], 8'h22);
    end_sim();
  end
endmodule
